// ### verilog/vrc_top.sv
// reference control register bank with analog control outputs
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module vrc_top
   import vrc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output vrc_analog_t analog_ctl
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] reference_control_r, reference_control_nxt;
   vrc_analog_t analog_r, analog_nxt;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] rd_value;

   // bus front end; registered outputs throughout
   vrc_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_data(wr_data),
      .rd_value(rd_value)
   );

   // ----------------------------------------------------------------
   // register update
   // ----------------------------------------------------------------
   // ready bit is masked out of storage, so it never holds written data
   always_comb begin
      reference_control_nxt = reference_control_r;
      if (wr_en) begin
         reference_control_nxt = wr_data & VRC_WRITE_MASK;
      end
   end

   // readback: ready flag forced high, no settling model on this part
   always_comb begin
      rd_value = reference_control_r;
      rd_value[VRC_READY_BIT] = VRC_READY_VALUE;
   end

   // analog controls follow the stored fields one cycle later
   always_comb begin
      analog_nxt.ref_on = reference_control_r[VRC_REF_ON_BIT];
      analog_nxt.temp_sense_on = reference_control_r[VRC_TS_ON_BIT];
      analog_nxt.temp_range_high = reference_control_r[VRC_TS_RANGE_BIT];
      analog_nxt.comparator_buffer_gain =
         vrc_gain_t'(reference_control_r[VRC_CMP_GAIN_LSB +: 2]);
      analog_nxt.converter_buffer_gain =
         vrc_gain_t'(reference_control_r[VRC_ADC_GAIN_LSB +: 2]);
      // sensor path to the converter mux exists whenever the sensor is powered
      analog_nxt.temp_to_adc = reference_control_r[VRC_TS_ON_BIT];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reference_control_r <= VRC_REFCTL_RESET;
         analog_r <= '0;
      end else begin
         reference_control_r <= reference_control_nxt;
         analog_r <= analog_nxt;
      end
   end

   assign analog_ctl = analog_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_ref_on_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en ##2 1'b1 |-> analog_ctl.ref_on == $past(wr_data[VRC_REF_ON_BIT], 2))
      else $error("reference enable output does not follow write");
   a_ready_reads_one: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[VRC_READY_BIT])
      else $error("ready flag read as zero");
   a_ts_on_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en ##2 1'b1 |-> analog_ctl.temp_sense_on == $past(wr_data[VRC_TS_ON_BIT], 2))
      else $error("sensor enable output does not follow write");
   a_range_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en ##2 1'b1 |-> analog_ctl.temp_range_high == $past(wr_data[VRC_TS_RANGE_BIT], 2))
      else $error("range select output does not follow write");
   a_cmp_gain_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en ##2 1'b1 |-> analog_ctl.comparator_buffer_gain == $past(wr_data[3:2], 2))
      else $error("comparator gain output does not follow write");
   a_adc_gain_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en ##2 1'b1 |-> analog_ctl.converter_buffer_gain == $past(wr_data[1:0], 2))
      else $error("converter gain output does not follow write");
   a_sensor_routed: assert property (@(posedge aclk) disable iff (!aresetn)
      analog_ctl.temp_to_adc == analog_ctl.temp_sense_on)
      else $error("sensor not routed to converter");
   a_ready_not_stored: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en |=> reference_control_r[VRC_READY_BIT] == 1'b0)
      else $error("ready flag took written data");
   a_write_resp_once: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");

   c_write_hit: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_en && wr_data[VRC_REF_ON_BIT]);
   c_read_ok: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
   c_read_err: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == 2'h2);
   c_gain_x4: cover property (@(posedge aclk) disable iff (!aresetn)
      analog_ctl.converter_buffer_gain == VRC_GAIN_X4);
   c_write_unmapped: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && s_axi_bresp == 2'h2);

   // ----------------------------------------------------------------
   // protocol, mirror and reset checks
   // ----------------------------------------------------------------
   // write side: a pending response blocks both address and data
   a_aw_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while response pending");
   a_bresp_held: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
      else $error("write response code changed before taken");
   a_bresp_code: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
      else $error("write response code out of set");
   a_store_once: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en |=> !wr_en)
      else $error("one write stored twice");
   a_store_answered: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en |-> s_axi_bvalid)
      else $error("store without write response");
   a_no_stray_change: assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_en |=> $stable(reference_control_r))
      else $error("register changed without a write");

   // read side: the answer stands unchanged until rready
   a_arready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arready |=> !s_axi_arready)
      else $error("read address ready longer than one cycle");
   a_rvalid_held: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped before taken");
   a_rdata_held: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before taken");
   a_rdata_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_err_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000)
      else $error("unmapped read returned data");

   // analog side tracks stored fields a cycle late; skipped right after reset
   a_ref_on_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> analog_ctl.ref_on == $past(reference_control_r[VRC_REF_ON_BIT]))
      else $error("reference enable output differs from stored bit");
   a_ts_on_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> analog_ctl.temp_sense_on == $past(reference_control_r[VRC_TS_ON_BIT]))
      else $error("sensor enable output differs from stored bit");
   a_range_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
         analog_ctl.temp_range_high == $past(reference_control_r[VRC_TS_RANGE_BIT]))
      else $error("range select output differs from stored bit");
   a_cmp_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> analog_ctl.comparator_buffer_gain ==
         $past(reference_control_r[VRC_CMP_GAIN_LSB +: 2]))
      else $error("comparator gain output differs from stored field");
   a_adc_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> analog_ctl.converter_buffer_gain ==
         $past(reference_control_r[VRC_ADC_GAIN_LSB +: 2]))
      else $error("converter gain output differs from stored field");

   // reset: the synchronous clear shows at the very next edge
   // no disable here: the check is about the reset itself
   a_reset_clears: assert property (@(posedge aclk)
      !aresetn |=> reference_control_r == VRC_REFCTL_RESET && analog_ctl == '0)
      else $error("reset left a writable field set");
endmodule : vrc_top

// ### common/vrc_pkg.sv
// package: register map, field layout and link types for the reference control block
package vrc_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] VRC_REFCTL_OFFSET = 12'h90C;
   localparam logic [7:0] VRC_REFCTL_RESET = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int VRC_REF_ON_BIT = 7;
   localparam int VRC_READY_BIT = 6;
   localparam int VRC_TS_ON_BIT = 5;
   localparam int VRC_TS_RANGE_BIT = 4;
   localparam int VRC_CMP_GAIN_LSB = 2;
   localparam int VRC_ADC_GAIN_LSB = 0;
   // bits software may write; the ready flag is excluded
   localparam logic [7:0] VRC_WRITE_MASK = 8'hBF;
   // ready flag value on this device
   localparam logic VRC_READY_VALUE = 1'b1;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int VRC_CLK_HZ = 10000000;
   localparam int VRC_TS_SETTLE_MS = 200;
   localparam longint VRC_TS_SETTLE_CYC = longint'(VRC_TS_SETTLE_MS) * VRC_CLK_HZ / 1000;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      VRC_GAIN_OFF,
      VRC_GAIN_X1,
      VRC_GAIN_X2,
      VRC_GAIN_X4
   } vrc_gain_t;
   // analog control bundle driven to reference, sensor and buffers
   typedef struct packed {
      logic ref_on;
      logic temp_sense_on;
      logic temp_range_high;
      vrc_gain_t comparator_buffer_gain;
      vrc_gain_t converter_buffer_gain;
      logic temp_to_adc;
   } vrc_analog_t;
endpackage : vrc_pkg

// ### verilog/vrc_axil_slave.sv
// AXI4-Lite slave front end for the single reference control register
`timescale 1ns/1ps
module vrc_axil_slave
   import vrc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_value
);
   // ----------------------------------------------------------------
   // write channel state
   // ----------------------------------------------------------------
   logic aw_have_r, aw_have_nxt;
   logic [31:0] aw_addr_r, aw_addr_nxt;
   logic w_have_r, w_have_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic w_strb0_r, w_strb0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic wr_en_r, wr_en_nxt;
   logic [7:0] wr_data_r, wr_data_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic aw_hit, ar_hit;

   // address and data are caught in either order, answered once both are in
   always_comb begin
      aw_have_nxt = aw_have_r;
      aw_addr_nxt = aw_addr_r;
      w_have_nxt = w_have_r;
      w_data_nxt = w_data_r;
      w_strb0_nxt = w_strb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      wr_en_nxt = 1'b0;
      wr_data_nxt = wr_data_r;
      aw_hit = (aw_addr_r[31:2] == {20'h00000, VRC_REFCTL_OFFSET[11:2]});
      if (s_axi_awvalid && !aw_have_r && !bvalid_r) begin
         aw_have_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r && !bvalid_r) begin
         w_have_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb0_nxt = s_axi_wstrb[0];
      end
      if (aw_have_r && w_have_r && !bvalid_r) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         // unmapped address answers SLVERR and stores nothing
         bresp_nxt = aw_hit ? 2'h0 : 2'h2;
         wr_en_nxt = aw_hit && w_strb0_r;
         wr_data_nxt = w_data_r[7:0];
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      // readies registered so every top output leaves a flop
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt = !w_have_nxt && !bvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 32'h00000000;
         w_have_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         wr_en_r <= 1'b0;
         wr_data_r <= 8'h00;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
      end else begin
         aw_have_r <= aw_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_have_r <= w_have_nxt;
         w_data_r <= w_data_nxt;
         w_strb0_r <= w_strb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         wr_en_r <= wr_en_nxt;
         wr_data_r <= wr_data_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read channel: arready is a registered one-cycle pulse
   // ----------------------------------------------------------------
   always_comb begin
      arready_nxt = 1'b0;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      ar_hit = (s_axi_araddr[31:2] == {20'h00000, VRC_REFCTL_OFFSET[11:2]});
      if (s_axi_arvalid && !arready_r && !rvalid_r) begin
         arready_nxt = 1'b1;
         rvalid_nxt = 1'b1;
         rdata_nxt = ar_hit ? {24'h000000, rd_value} : 32'h00000000;
         rresp_nxt = ar_hit ? 2'h0 : 2'h2;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else begin
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign wr_en = wr_en_r;
   assign wr_data = wr_data_r;
endmodule : vrc_axil_slave

// ### tb/test_voltage_reference_control.sv
// self-checking bench for the reference control register bank
`timescale 1ns/1ps
module test_voltage_reference_control
   import vrc_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic aclk, aresetn;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   vrc_analog_t analog_ctl;
   int bad_count, n_checks, cycles;
   logic [31:0] rd;
   logic [1:0] rsp;
   localparam logic [31:0] REG_ADDR = {20'h00000, VRC_REFCTL_OFFSET};

   vrc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .analog_ctl(analog_ctl));

   // 10 MHz clock and hang guard; a stuck handshake ends in the report
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // each request holds until the rising edge that samples its own ready high
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // response taken at the edge that samples bvalid high
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // read data may already stand at the edge that takes the address
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // write a value, then check the analog outputs and the read-back
   task automatic wr_chk(input logic [7:0] v);
      logic [7:0] e;
      e = {v[7], v[5], v[4], v[3:2], v[1:0], v[5]};
      axi_write(REG_ADDR, {24'h000000, v}, 4'hF, rsp);
      check("bresp", {30'h0, rsp}, 32'h00000000);
      // register loads at the response edge, the analog side one edge later
      repeat (2) @(negedge aclk);
      check("analog_ctl", {24'h0, analog_ctl}, {24'h0, e});
      axi_read(REG_ADDR, rd, rsp);
      check("readback", rd, {24'h000000, v | 8'h40});
   endtask : wr_chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_checks = 0;
      cycles = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // reset state: writable fields zero, ready flag one
      axi_read(REG_ADDR, rd, rsp);
      check("reset value", rd, 32'h00000040);
      check("reset analog", {24'h0, analog_ctl}, 32'h00000000);
      // each single control bit, then back to all off
      wr_chk(8'h80);
      // sensor powered, but no conversion is started, so no settle wait or averaging is due
      wr_chk(8'h20);
      wr_chk(8'h10);
      wr_chk(8'h00);
      // every pairing of the two buffer gain codes
      for (int c = 0; c < 4; c++) begin
         for (int g = 0; g < 4; g++) begin
            wr_chk({4'h0, c[1:0], g[1:0]});
         end
      end
      // writing a zero into the ready flag position leaves it reading one
      wr_chk(8'hBF);
      wr_chk(8'hFF);
      // no byte enabled: accepted but nothing stored
      axi_write(REG_ADDR, 32'h00000000, 4'h0, rsp);
      check("bresp no strobe", {30'h0, rsp}, 32'h00000000);
      axi_read(REG_ADDR, rd, rsp);
      check("kept no strobe", rd, 32'h000000FF);
      // neighbouring addresses are not the register
      axi_write(REG_ADDR - 32'h4, 32'h00000000, 4'hF, rsp);
      check("bresp unmapped", {30'h0, rsp}, 32'h00000002);
      axi_read(REG_ADDR, rd, rsp);
      check("kept unmapped", rd, 32'h000000FF);
      axi_read(REG_ADDR + 32'h4, rd, rsp);
      check("rdata unmapped", rd, 32'h00000000);
      check("rresp unmapped", {30'h0, rsp}, 32'h00000002);
      // reset in mid-run clears every writable field
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check("analog after reset", {24'h0, analog_ctl}, 32'h00000000);
      axi_read(REG_ADDR, rd, rsp);
      check("value after reset", rd, 32'h00000040);
      wrap_up();
   end
endmodule : test_voltage_reference_control
